// ---- core/rtes_top.sv ----
// Event time stamp and minute alarm interrupt logic with AXI4-Lite registers
// Behaviour
// - Valid event copies time and supply flags
// - Event flag sets with the event
// - Event flag holds until zero written
// - Enabled event drives interrupt low
// - Low holds until flag or enable clears
// - Clearing event enable releases output immediately
// - Clearing event flag releases output immediately
// - Disabled event sets flag, output stays released
// - Four sources share one interrupt output
// - Alarm match sets flag, drives output
// - Alarm compared only at minute update
// - Counter reset bit blocks alarm events
// - Ignore bit forces field match
// - Select bit picks weekday or date
// - Weekday bitmap matches any selected day
// - Protected bits ignore writes, read zero
// - Spare alarm bits are plain storage
// - Alarm registers as storage need enable off
// - Zero clears alarm flag, one keeps
// - Clearing alarm enable releases output
// - Current-time setting fires only next reach
`timescale 1ns/1ps

module rtes_top
  import rtes_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // Time counters (packed BCD, weekday as bitmap) and minute update strobe
  input  wire logic [7:0]        timeMinute,
  input  wire logic [7:0]        timeHour,
  input  wire logic [6:0]        timeWeekday,
  input  wire logic [7:0]        timeDate,
  input  wire logic              minuteUpdate,
  // Supply monitor levels
  input  wire logic              voltageDetect,
  input  wire logic              voltageLow,
  // Other interrupt sources, one-cycle event pulses
  input  wire logic              wakeupTimerEvent,
  input  wire logic              updateEvent,
  // Event input, already at the active level when high
  input  wire logic              eventInputPin,
  // Shared open-drain interrupt pin, active low
  output logic                   intPinOut,
  output logic                   intPinOe_n
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] alarmMin;       // Minute alarm, BCD
  logic [7:0] alarmHour;      // Hour alarm, BCD
  logic [7:0] alarmDay;       // Weekday bitmap or date BCD
  logic [7:0] ctrl1;          // First control
  logic [7:0] ctrl2;          // Second control
  logic [7:0] evCtrl;         // Event input control
  logic       updateFlag;     // Sticky flags
  logic       wakeupTimerFlag;
  logic       alarmFlag;
  logic       eventFlag;
  logic [7:0] stampMin;       // Captured time stamp
  logic [7:0] stampHour;
  logic [7:0] stampDay;
  logic [1:0] stampSupply;    // Captured detect and low flags
  logic       vdetFlag;       // Sticky supply flags
  logic       vlowFlag;

  // ****************************************************************
  // AXI4-Lite slave: holds address and data until both present
  // ****************************************************************
  logic              awHeld;
  logic              wHeld;
  logic [ADDR_W-1:0] awAddr;
  logic [31:0]       wData;
  logic              wStrb0;
  logic              wrFire;
  logic [7:0]        wrIdx;
  logic              wrHit;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign wrFire        = awHeld && wHeld;
  assign wrIdx         = awAddr[ADDR_W-1:2];
  assign s_axi_bresp   = RESP_OKAY;

  // Capture address and data in either order
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= '0;
      wData  <= '0;
      wStrb0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld  <= 1'b1;
        wData  <= s_axi_wdata;
        wStrb0 <= s_axi_wstrb[0];
      end else if (wrFire) begin
        wHeld <= 1'b0;
      end
    end
  end

  // Write response; unmapped writes are dropped but still answered OKAY
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 carries data; other lanes are ignored
  logic       wrEn;
  logic [7:0] wb;
  assign wrEn = wrFire && wStrb0 && wrHit;
  assign wb   = wData[7:0];

  always_comb begin
    case (wrIdx)
      IDX_ALARM_MIN, IDX_ALARM_HOUR, IDX_ALARM_DAY, IDX_CTRL1, IDX_FLAGS,
      IDX_CTRL2, IDX_EVCTRL, IDX_EVFLAG,
      IDX_STAMP_MIN, IDX_STAMP_HOUR, IDX_STAMP_DAY, IDX_STAMP_SUP: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Alarm bytes are full storage: spare bits keep any value
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alarmMin  <= RST_ZERO;
      alarmHour <= RST_ZERO;
      alarmDay  <= RST_ZERO;
      ctrl1     <= RST_ZERO;
      ctrl2     <= RST_ZERO;
      evCtrl    <= RST_ZERO;
    end else if (wrEn) begin
      case (wrIdx)
        IDX_ALARM_MIN:  alarmMin  <= wb;
        IDX_ALARM_HOUR: alarmHour <= wb;
        IDX_ALARM_DAY:  alarmDay  <= wb;
        IDX_CTRL1:      ctrl1     <= wb;
        IDX_CTRL2:      ctrl2     <= wb & MASK_CTRL2;
        IDX_EVCTRL:     evCtrl    <= wb & MASK_EVCTRL;
        default: begin
        end
      endcase
    end
  end

  // Flag write strobes: a written zero clears, a one keeps
  logic wrFlags;
  logic wrEvFlag;
  assign wrFlags  = wrEn && (wrIdx == IDX_FLAGS);
  assign wrEvFlag = wrEn && (wrIdx == IDX_EVFLAG);

  // ****************************************************************
  // Event input qualification
  // ****************************************************************
  // Counts how long the pin stays active; fires once per pulse
  logic [EVCNT_W-1:0] evCount;
  logic               evDone;
  logic               eventHit;
  assign eventHit = eventInputPin && !evDone && (evCount == EVCNT_W'(EV_MIN_CYC));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      evCount <= '0;
      evDone  <= 1'b0;
    end else if (!eventInputPin) begin
      evCount <= '0;
      evDone  <= 1'b0;
    end else begin
      if (evCount != EVCNT_W'(EV_MIN_CYC)) begin
        evCount <= evCount + 1'b1;
      end
      if (eventHit) begin
        evDone <= 1'b1;
      end
    end
  end

  // Time stamp capture with the supply flags of that moment
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stampMin    <= RST_ZERO;
      stampHour   <= RST_ZERO;
      stampDay    <= RST_ZERO;
      stampSupply <= 2'h0;
    end else if (eventHit) begin
      stampMin    <= timeMinute;
      stampHour   <= timeHour;
      stampDay    <= timeDate;
      stampSupply <= {vlowFlag, vdetFlag};
    end
  end

  // ****************************************************************
  // Alarm comparator
  // ****************************************************************
  logic minMatch;
  logic hourMatch;
  logic dayMatch;
  logic alarmHit;
  always_comb begin
    minMatch  = alarmMin[BIT_IGNORE] || (alarmMin[6:0] == timeMinute[6:0]);
    hourMatch = alarmHour[BIT_IGNORE] || (alarmHour[5:0] == timeHour[5:0]);
    if (alarmDay[BIT_IGNORE]) begin
      dayMatch = 1'b1;
    end else if (ctrl1[BIT_WDSEL]) begin
      dayMatch = (alarmDay[5:0] == timeDate[5:0]);
    end else begin
      dayMatch = |(alarmDay[6:0] & timeWeekday);
    end
  end
  // Only the minute strobe compares, so a setting equal to now waits
  assign alarmHit = minuteUpdate && !ctrl2[BIT_CRESET]
                    && minMatch && hourMatch && dayMatch;

  // ****************************************************************
  // Sticky flags: set wins over a clear in the same cycle
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alarmFlag       <= 1'b0;
      wakeupTimerFlag <= 1'b0;
      updateFlag      <= 1'b0;
      vdetFlag        <= 1'b0;
      vlowFlag        <= 1'b0;
    end else begin
      alarmFlag       <= alarmHit || (alarmFlag && !(wrFlags && !wb[BIT_AF]));
      wakeupTimerFlag <= wakeupTimerEvent || (wakeupTimerFlag && !(wrFlags && !wb[BIT_TF]));
      updateFlag      <= updateEvent || (updateFlag && !(wrFlags && !wb[BIT_UF]));
      vdetFlag        <= voltageDetect || (vdetFlag && !(wrFlags && !wb[BIT_VOLTAGE_DETECT_FLAG]));
      vlowFlag        <= voltageLow || (vlowFlag && !(wrFlags && !wb[BIT_VLF]));
    end
  end

  // Event flag rises with the qualified event and holds until zero written
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eventFlag <= 1'b0;
    end else begin
      eventFlag <= eventHit || (eventFlag && !(wrEvFlag && !wb[BIT_EF]));
    end
  end

  // ****************************************************************
  // Shared interrupt output
  // ****************************************************************
  // Pure gating of flags by enables: dropping either releases at once
  logic intActive;
  assign intActive = (eventFlag && evCtrl[BIT_EIE])
                   | (alarmFlag && ctrl2[BIT_AIE])
                   | (wakeupTimerFlag && ctrl2[BIT_TIE])
                   | (updateFlag && ctrl2[BIT_UIE]);
  assign intPinOut  = 1'b0;       // Open drain only ever pulls low
  assign intPinOe_n = !intActive; // Low enable drives the pin

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic [7:0] rdByte;
  logic       rdHit;
  logic [7:0] rdIdx;
  assign rdIdx = s_axi_araddr[ADDR_W-1:2];

  // Read mux; protected bits come back zero
  always_comb begin
    rdHit = 1'b1;
    case (rdIdx)
      IDX_ALARM_MIN:  rdByte = alarmMin;
      IDX_ALARM_HOUR: rdByte = alarmHour;
      IDX_ALARM_DAY:  rdByte = alarmDay;
      IDX_CTRL1:      rdByte = ctrl1;
      IDX_FLAGS:      rdByte = {2'h0, updateFlag, wakeupTimerFlag, alarmFlag, 1'b0, vlowFlag, vdetFlag};
      IDX_CTRL2:      rdByte = ctrl2;
      IDX_EVCTRL:     rdByte = evCtrl;
      IDX_EVFLAG:     rdByte = {eventFlag, 3'h0, eventInputPin, 3'h0};
      IDX_STAMP_MIN:  rdByte = stampMin;
      IDX_STAMP_HOUR: rdByte = stampHour;
      IDX_STAMP_DAY:  rdByte = stampDay;
      IDX_STAMP_SUP:  rdByte = {6'h00, stampSupply};
      default: begin
        rdByte = RST_ZERO;
        rdHit  = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Registered read data, one cycle after the address is taken
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rdByte};
      s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // rtes_top

// ---- core/rtes_pkg.sv ----
// Package: register map, field positions and timing constants of the event stamp and alarm block
package rtes_pkg;

  // ****************************************************************
  // Register byte offsets (printed offsets are indices, byte = 4x)
  // ****************************************************************
  localparam logic [7:0] IDX_ALARM_MIN   = 8'h08;
  localparam logic [7:0] IDX_ALARM_HOUR  = 8'h09;
  localparam logic [7:0] IDX_ALARM_DAY   = 8'h0A;
  localparam logic [7:0] IDX_CTRL1       = 8'h0D;
  localparam logic [7:0] IDX_FLAGS       = 8'h0E;
  localparam logic [7:0] IDX_CTRL2       = 8'h0F;
  localparam logic [7:0] IDX_EVCTRL      = 8'h17;
  localparam logic [7:0] IDX_EVFLAG      = 8'h18;
  localparam logic [7:0] IDX_STAMP_MIN   = 8'h20;
  localparam logic [7:0] IDX_STAMP_HOUR  = 8'h21;
  localparam logic [7:0] IDX_STAMP_DAY   = 8'h22;
  localparam logic [7:0] IDX_STAMP_SUP   = 8'h23;
  localparam int         ADDR_W          = 10;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_IGNORE   = 7;  // Alarm match ignore
  localparam int BIT_WDSEL    = 6;  // First_control weekday/date select
  localparam int BIT_UF       = 5;
  localparam int BIT_TF       = 4;
  localparam int BIT_AF       = 3;
  localparam int BIT_VLF      = 1;
  localparam int BIT_VOLTAGE_DETECT_FLAG     = 0;
  localparam int BIT_UIE      = 5;
  localparam int BIT_TIE      = 4;
  localparam int BIT_AIE      = 3;
  localparam int BIT_CRESET   = 0;
  localparam int BIT_EIE      = 3;
  localparam int BIT_EF       = 7;
  localparam int BIT_EVENT_LEVEL_MONITOR    = 3;

  // Writable masks: write-protected bits read zero
  localparam logic [7:0] MASK_CTRL2  = 8'hF9;
  localparam logic [7:0] MASK_EVCTRL = 8'hFB;
  localparam logic [7:0] MASK_MIN    = 8'hFF;
  localparam logic [7:0] RST_ZERO    = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Timing: event pulse must exceed this width
  // ****************************************************************
  localparam int CLK_HZ       = 10_000_000;
  localparam int EV_MIN_NS    = 60_000;
  localparam int EV_MIN_CYC   = (EV_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int EVCNT_W      = 10;

endpackage : rtes_pkg

// ---- tb/rtes_checker.sv ----
// Checker: concurrent properties on the ports of the event stamp and alarm block
`timescale 1ns/1ps
module rtes_checker
  import rtes_pkg::*;
(
  // Clock, reset and register bus handshakes
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Interrupt sources and shared pin
  input wire logic        minuteUpdate,
  input wire logic        wakeupTimerEvent,
  input wire logic        updateEvent,
  input wire logic        eventInputPin,
  input wire logic        intPinOut,
  input wire logic        intPinOe_n
);
  // ****************************************************************
  // Helper logic and sequences
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [12:0] evRun;  // Consecutive high samples of the event input
  // Saturating run counter, so a stuck-high input never wraps into a false cause
  always_ff @(posedge sys_clk) begin
    if (rst || !eventInputPin) evRun <= 13'h0000;
    else if (evRun != 13'h1FFF) evRun <= evRun + 13'h0001;
  end
  // Register write applied by the slave
  sequence wrApplied;
    $rose(s_axi_bvalid);
  endsequence
  // Some interrupt source fired on the previous edge
  sequence srcFired;
    $past(minuteUpdate) || $past(wakeupTimerEvent) || $past(updateEvent) || (evRun == 13'(EV_MIN_CYC + 1));
  endsequence
  // ****************************************************************
  // Properties
  // ****************************************************************
  pin_level_a: assert property (!intPinOe_n |-> intPinOut == 1'b0)
    else $error("Interrupt pin driven high");
  low_cause_a: assert property ($fell(intPinOe_n) |-> wrApplied or srcFired)
    else $error("Interrupt pin went low without a cause");
  low_hold_a: assert property ($rose(intPinOe_n) |-> wrApplied)
    else $error("Interrupt pin released without a register write");
  reset_idle_a: assert property (disable iff (1'b0) rst |=> intPinOe_n && !s_axi_bvalid && !s_axi_rvalid)
    else $error("Outputs not idle after reset");
  b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early");
  b_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY)
    else $error("Write response not OKAY");
  r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped early");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
    else $error("Read answer late or upper bits set");
  ar_gate_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("Read address ready not gated by read valid");
endmodule // rtes_checker

bind rtes_top rtes_checker chk_u (
  .sys_clk, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .minuteUpdate, .wakeupTimerEvent,
  .updateEvent, .eventInputPin, .intPinOut, .intPinOe_n
);

// ---- tb/rtes_host_model.sv ----
// Host-side model: pull-up resolution of the shared interrupt line
`timescale 1ns/1ps
module rtes_host_model (
  // Device interrupt pin
  input  wire logic intPinOut,
  input  wire logic intPinOe_n,
  // Level seen by the host
  output logic      intLine
);
  // Pull-up holds the line high unless one of the four sources pulls it low
  assign intLine = intPinOe_n ? 1'b1 : intPinOut;
endmodule // rtes_host_model

// ---- tb/rtes_top_tb.sv ----
// Testbench: register, event stamp and alarm scenarios for the block
`timescale 1ns/1ps
module rtes_top_tb
  import rtes_pkg::*;
;
  localparam int CYC_MAX = 40000;  // Three long event pulses plus register traffic
  logic              sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rr;
  logic [7:0]        timeMinute, timeHour, timeDate, am, ah, ad;
  logic [6:0]        timeWeekday;
  logic              minuteUpdate, voltageDetect, voltageLow, wakeupTimerEvent, updateEvent, eventInputPin;
  logic              intPinOut, intPinOe_n, intLine, sel, hit;
  int                failures, n_tests, cyc, seed;
  // Every register that resets to zero, stamps included
  localparam logic [7:0] IDX_LIST [12] = '{IDX_ALARM_MIN, IDX_ALARM_HOUR, IDX_ALARM_DAY, IDX_CTRL1, IDX_FLAGS,
    IDX_CTRL2, IDX_EVCTRL, IDX_EVFLAG, IDX_STAMP_MIN, IDX_STAMP_HOUR, IDX_STAMP_DAY, IDX_STAMP_SUP};

  rtes_top dut_u (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .timeMinute, .timeHour,
    .timeWeekday, .timeDate, .minuteUpdate, .voltageDetect, .voltageLow, .wakeupTimerEvent, .updateEvent,
    .eventInputPin, .intPinOut, .intPinOe_n);
  rtes_host_model host_u (.intPinOut, .intPinOe_n, .intLine);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Sample at the falling edge, where ready and valid are settled, then hand over at the rising edge
  task automatic waitHi(ref logic s);
    do begin
      @(negedge sys_clk);
      hit = s;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge sys_clk);
    end while (!hit);
  endtask
  task automatic wrReg(input logic [7:0] idx, input logic [7:0] d);
    logic a, w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    a = 1'b0;
    w = 1'b0;
    while (!(a && w)) begin
      @(negedge sys_clk);
      a = a || s_axi_awready;
      w = w || s_axi_wready;
      @(posedge sys_clk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    // Late ready lets the response stand a cycle unanswered
    repeat (2) @(posedge sys_clk);
    s_axi_bready <= 1'b1;
    waitHi(s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  // Read one register and compare its data word
  task automatic expReg(input string nm, input logic [7:0] idx, input logic [7:0] e);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= {idx, 2'b00};
    waitHi(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge sys_clk);
    s_axi_rready <= 1'b1;
    waitHi(s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(nm, rd, {24'h000000, e});
  endtask
  task automatic chkPin(input string nm, input logic e);
    @(negedge sys_clk);
    chk(nm, {31'h0, intLine}, {31'h0, e});
    @(posedge sys_clk);
  endtask
  // Pulse strobes {low, detect, update, wakeup, minute} for one cycle; flags land at that edge
  task automatic pulse(input logic [4:0] k);
    {voltageLow, voltageDetect, updateEvent, wakeupTimerEvent, minuteUpdate} <= k;
    @(posedge sys_clk);
    {voltageLow, voltageDetect, updateEvent, wakeupTimerEvent, minuteUpdate} <= 5'h00;
    @(posedge sys_clk);
  endtask
  task automatic evPulse(input int n);
    eventInputPin <= 1'b1;
    repeat (n) @(posedge sys_clk);
    eventInputPin <= 1'b0;
    @(posedge sys_clk);
  endtask
  function automatic int rnd(input int n);
    return ($random(seed) & 32'h7FFFFFFF) % n;
  endfunction
  function automatic logic [7:0] bcd(input int n);
    int v;
    v = rnd(n);
    return 8'((v / 10) * 16 + v % 10);
  endfunction
  // Expected alarm match from the programmed fields and the time inputs
  function automatic logic alarmHit(input logic [7:0] m, input logic [7:0] h, input logic [7:0] d, input logic s);
    return (m[7] || m[6:0] == timeMinute[6:0]) && (h[7] || h[5:0] == timeHour[5:0])
      && (d[7] || (s ? d[5:0] == timeDate[5:0] : |(d[6:0] & timeWeekday)));
  endfunction

  // ****************************************************************
  // Clock, timeout and main sequence
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == CYC_MAX) begin
      failures++;
      close_out();
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {timeMinute, timeHour, timeDate, timeWeekday} = '0;
    {minuteUpdate, voltageDetect, voltageLow, wakeupTimerEvent, updateEvent, eventInputPin} = 6'h00;
    {failures, n_tests, cyc} = '0;
    seed = 17;
    rst = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // Reset values, protected bits and spare storage
    foreach (IDX_LIST[i]) expReg("reset value", IDX_LIST[i], 8'h00);
    expReg("unmapped data", 8'h30, 8'h00);
    chk("unmapped resp", {30'h0, rr}, {30'h0, RESP_SLVERR});
    wrReg(IDX_CTRL2, 8'hFF);
    expReg("ctrl2 mask", IDX_CTRL2, 8'hF9);
    wrReg(IDX_CTRL2, 8'h00);
    wrReg(IDX_EVCTRL, 8'hFF);
    expReg("event ctrl mask", IDX_EVCTRL, 8'hFB);
    wrReg(IDX_EVCTRL, 8'h00);
    wrReg(IDX_FLAGS, 8'hFF);
    expReg("flags keep", IDX_FLAGS, 8'h00);
    am = 8'(rnd(256));
    ah = 8'(rnd(256));
    wrReg(IDX_ALARM_MIN, am);
    wrReg(IDX_ALARM_HOUR, ah);
    wrReg(IDX_ALARM_DAY, 8'hFF);
    expReg("hour storage", IDX_ALARM_HOUR, ah);
    expReg("min storage", IDX_ALARM_MIN, am);
    pulse(5'h01);
    chkPin("storage quiet", 1'b1);
    wrReg(IDX_FLAGS, 8'h00);
    $display("Test %s done", "registers");
    // Other sources share the pin; polling finds them with enables off
    pulse(5'h06);
    chkPin("polled quiet", 1'b1);
    expReg("polled flags", IDX_FLAGS, 8'h30);
    wrReg(IDX_CTRL2, 8'h30);
    chkPin("shared low", 1'b0);
    wrReg(IDX_FLAGS, 8'h00);
    chkPin("shared released", 1'b1);
    wrReg(IDX_CTRL2, 8'h00);
    $display("Test %s done", "sources");
    // Event stamp: setup order, width boundary, capture and release paths
    wrReg(IDX_EVCTRL, 8'h00);
    wrReg(IDX_EVFLAG, 8'h00);
    wrReg(IDX_EVCTRL, 8'h08);
    am = bcd(60);
    ah = bcd(24);
    ad = bcd(32);
    timeMinute <= am;
    timeHour <= ah;
    timeDate <= ad;
    pulse(5'h18);
    evPulse(EV_MIN_CYC);
    chkPin("short pulse", 1'b1);
    expReg("short flag", IDX_EVFLAG, 8'h00);
    evPulse(EV_MIN_CYC + 1);
    timeMinute <= bcd(60);
    chkPin("event low", 1'b0);
    expReg("event flag", IDX_EVFLAG, 8'h80);
    expReg("stamp minute", IDX_STAMP_MIN, am);
    expReg("stamp hour", IDX_STAMP_HOUR, ah);
    expReg("stamp date", IDX_STAMP_DAY, ad);
    expReg("stamp supply", IDX_STAMP_SUP, 8'h03);
    wrReg(IDX_EVFLAG, 8'h80);
    expReg("flag held", IDX_EVFLAG, 8'h80);
    chkPin("low held", 1'b0);
    wrReg(IDX_EVCTRL, 8'h00);
    chkPin("enable off", 1'b1);
    wrReg(IDX_EVCTRL, 8'h08);
    chkPin("enable on", 1'b0);
    wrReg(IDX_EVFLAG, 8'h00);
    chkPin("flag cleared", 1'b1);
    wrReg(IDX_EVCTRL, 8'h00);
    evPulse(EV_MIN_CYC + 1);
    chkPin("disabled event", 1'b1);
    expReg("disabled flag", IDX_EVFLAG, 8'h80);
    wrReg(IDX_FLAGS, 8'h00);
    $display("Test %s done", "event");
    // Alarm: random fields, ignore bits, weekday bitmap or date
    for (int i = 0; i < 24; i++) begin
      wrReg(IDX_CTRL2, 8'h00);
      timeMinute <= bcd(60);
      timeHour <= bcd(24);
      timeDate <= bcd(32);
      timeWeekday <= 7'h01 << rnd(7);
      @(posedge sys_clk);
      sel = 1'(rnd(2));
      am = (rnd(3) == 0) ? bcd(60) : timeMinute | {rnd(4) == 0, 7'h00};
      ah = (rnd(3) == 0) ? bcd(24) : timeHour | {rnd(4) == 0, 7'h00};
      ad = sel ? ((rnd(3) == 0) ? bcd(32) : timeDate) : 8'(rnd(256));
      wrReg(IDX_CTRL1, {1'b0, sel, 6'h00});
      wrReg(IDX_ALARM_MIN, am);
      wrReg(IDX_ALARM_HOUR, ah);
      wrReg(IDX_ALARM_DAY, ad);
      wrReg(IDX_CTRL2, 8'h08);
      chkPin("no early alarm", 1'b1);
      pulse(5'h01);
      hit = alarmHit(am, ah, ad, sel);
      chkPin("alarm pin", !hit);
      expReg("alarm flag", IDX_FLAGS, {4'h0, hit, 3'h0});
      wrReg(IDX_FLAGS, 8'h00);
    end
    wrReg(IDX_ALARM_MIN, 8'h80);
    wrReg(IDX_ALARM_HOUR, 8'h80);
    wrReg(IDX_ALARM_DAY, 8'h80);
    wrReg(IDX_CTRL2, 8'h09);
    pulse(5'h01);
    expReg("counter reset", IDX_FLAGS, 8'h00);
    wrReg(IDX_CTRL2, 8'h08);
    pulse(5'h01);
    chkPin("every minute", 1'b0);
    wrReg(IDX_FLAGS, 8'h08);
    chkPin("alarm kept", 1'b0);
    wrReg(IDX_CTRL2, 8'h00);
    chkPin("alarm enable off", 1'b1);
    wrReg(IDX_CTRL2, 8'h08);
    wrReg(IDX_FLAGS, 8'h00);
    chkPin("alarm cleared", 1'b1);
    $display("Test %s done", "alarm");
    close_out();
  end
endmodule // rtes_top_tb
